// file: ccd_sweep_shutter_timing.v
/*
 Sweep repetition control, auxiliary vertical pulse combiner and
 substrate-clear shutter pulse generator of a CCD timing generator.
 Assumes a vertical sequencer outside that reports the current region
 and each finished vertical repetition, and one-cycle line and field
 sync pulses, all synchronous to CLOCK.
*/
// Notes on behaviour
// - Pulse sequences stay in one line, except sweep regions ignore line ends until done.
// - Sweep repetition only ever happens in region 0 and region 3.
// - Sweep select: 00 none, 01 region 0, 10 region 3, 11 both.
// - Sweep repeat counts per region reach up to 2048 pulses.
// - Auxiliary vertical pulse appears only in the sensor-gate line.
// - Auxiliary enable: 0 disables, 1 enables the auxiliary pulse.
// - Logic select bit per phase, bit 0 phase 1; 0 is OR, 1 is AND.
// - AND phase: auxiliary waveform starts high, falls at start position.
// - OR phase: auxiliary waveform starts low, rises at start position.
// - Thirteen-bit start and end positions compared with sensor-gate pixel counter.
// - Eleven-bit count sets substrate-clear pulses per field, 0 to 2047.
// - Skip control removes first substrate-clear pulse after the sensor-gate line.
// - Shutter enable: 0 disables, 1 enables the substrate-clear output.
// - Fast mode bit and three-bit fast count steer high-speed shutter pulses.
// - Two toggle sets of nine-bit positions, compared with line pixel counter.
// - Toggle set select: 0 first set, 1 second set.
// - Normal mode gives one substrate-clear pulse per line until count spent.
// - Pulses start on the line right after the programmed sensor-gate line.
// - Substrate-clear idles high, falls at first, rises at second position.
// - Fast count 0 normal; mode 0 extra pulse at slot n; mode 1 n extras.
`include "ccd_timing_consts.vh"
`timescale 1ns/100ps

module ccd_sweep_shutter_timing (
    // Clock and reset
    input wire CLOCK,
    input wire RST_B,
    // Register port
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    output reg [31:0] REG_RDATA,
    // Frame timing
    input wire LINE_SYNC,
    input wire FIELD_SYNC,
    input wire [6:0] SENSOR_GATE_LINE,
    // Vertical sequencer
    input wire [2:0] REGION,
    input wire VPULSE_DONE,
    input wire [3:0] VPHASE_IN,
    output wire SWEEP_HOLD,
    output wire [3:0] VPHASE_OUT,
    // Substrate clear
    output reg SUBSTRATE_CLEAR
);

    // Control fields
    reg shutter_first_pulse_skip;
    reg fast_shutter_mode;
    reg [1:0] sweep_region_select;
    reg aux_vpulse_enable;
    reg [3:0] aux_vpulse_logic_select;
    reg [10:0] shutter_pulse_count;
    reg shutter_output_enable;
    reg [2:0] fast_shutter_count;
    reg [11:0] sweep_repeat_region0;
    reg [11:0] sweep_repeat_region3;
    reg [8:0] shutter_set1_fall_pos;
    reg [8:0] shutter_set1_rise_pos;
    reg [8:0] shutter_set2_fall_pos;
    reg [8:0] shutter_set2_rise_pos;
    reg shutter_toggle_set_select;
    reg [12:0] aux_vpulse_start_pos [0:3];
    reg [12:0] aux_vpulse_end_pos [0:3];

    // Timing state
    reg [12:0] line_pixel_counter;
    reg [12:0] sensor_gate_pixel_counter;
    reg [7:0] line_num;
    reg [2:0] last_region;
    reg [11:0] sweep_done;
    reg [10:0] shut_left;
    reg shut_armed;
    reg first_pending;
    reg shut_line;
    reg skip_line;
    reg slot_run;
    reg [3:0] slot;
    reg [8:0] slot_cnt;
    reg [31:0] rd_mux;

    wire sg_line_now;
    wire sweep_r0;
    wire sweep_r3;
    wire sweep_on;
    wire [11:0] sweep_target;
    wire [8:0] fall_pos;
    wire [8:0] rise_pos;
    wire [8:0] width;
    wire fall_hit;
    wire next_armed;
    wire [2:0] slot_pair;
    wire slot_used;
    wire low_now;

    // Clamp keeps a repeat count inside the 2048 the counter is built for
    function [11:0] clamp_repeat;
        input [11:0] value;
        begin
            clamp_repeat = (value > `SWEEP_REPEAT_MAX) ? `SWEEP_REPEAT_MAX : value;
        end
    endfunction

    // Register writes
    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            shutter_first_pulse_skip <= 1'b0;
            fast_shutter_mode <= 1'b0;
            sweep_region_select <= 2'h0;
            aux_vpulse_enable <= 1'b0;
            aux_vpulse_logic_select <= 4'h0;
            shutter_pulse_count <= 11'h000;
            shutter_output_enable <= 1'b0;
            fast_shutter_count <= 3'h0;
            sweep_repeat_region0 <= 12'h000;
            sweep_repeat_region3 <= 12'h000;
            shutter_set1_fall_pos <= 9'h000;
            shutter_set1_rise_pos <= 9'h000;
            shutter_set2_fall_pos <= 9'h000;
            shutter_set2_rise_pos <= 9'h000;
            shutter_toggle_set_select <= 1'b0;
        end else if (REG_WR) begin
            case (REG_ADDR)
                `ADDR_SHUTTER_CTRL: begin
                    shutter_first_pulse_skip <= REG_WDATA[`BIT_FIRST_PULSE_SKIP];
                    fast_shutter_mode <= REG_WDATA[`BIT_FAST_MODE];
                end
                `ADDR_AUX_CTRL: begin
                    sweep_region_select <= REG_WDATA[`BIT_SWEEP_SEL_LO +: 2];
                    aux_vpulse_enable <= REG_WDATA[`BIT_AUX_ENABLE];
                    aux_vpulse_logic_select <= REG_WDATA[`BIT_AUX_LOGIC_LO +: 4];
                end
                `ADDR_SHUTTER_NUM: begin
                    shutter_pulse_count <= REG_WDATA[`BIT_SHUT_COUNT_LO +: 11];
                    shutter_output_enable <= REG_WDATA[`BIT_SHUT_ENABLE];
                    fast_shutter_count <= REG_WDATA[`BIT_FAST_COUNT_LO +: 3];
                end
                `ADDR_SWEEP_REPEAT: begin
                    sweep_repeat_region0 <= clamp_repeat(REG_WDATA[11:0]);
                    sweep_repeat_region3 <= clamp_repeat(REG_WDATA[`BIT_HIGH_FIELD_LO +: 12]);
                end
                `ADDR_SHUT_SET1: begin
                    shutter_set1_fall_pos <= REG_WDATA[8:0];
                    shutter_set1_rise_pos <= REG_WDATA[`BIT_HIGH_FIELD_LO +: 9];
                end
                `ADDR_SHUT_SET2: begin
                    shutter_set2_fall_pos <= REG_WDATA[8:0];
                    shutter_set2_rise_pos <= REG_WDATA[`BIT_HIGH_FIELD_LO +: 9];
                end
                `ADDR_SHUT_SELECT: begin
                    shutter_toggle_set_select <= REG_WDATA[0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data is held in a flop so the port never shows a mux glitch
    always @* begin
        rd_mux = `REG_RESET;
        case (REG_ADDR)
            `ADDR_SHUTTER_CTRL: begin
                rd_mux[`BIT_FIRST_PULSE_SKIP] = shutter_first_pulse_skip;
                rd_mux[`BIT_FAST_MODE] = fast_shutter_mode;
            end
            `ADDR_AUX_CTRL: begin
                rd_mux[`BIT_SWEEP_SEL_LO +: 2] = sweep_region_select;
                rd_mux[`BIT_AUX_ENABLE] = aux_vpulse_enable;
                rd_mux[`BIT_AUX_LOGIC_LO +: 4] = aux_vpulse_logic_select;
            end
            `ADDR_SHUTTER_NUM: begin
                rd_mux[`BIT_SHUT_COUNT_LO +: 11] = shutter_pulse_count;
                rd_mux[`BIT_SHUT_ENABLE] = shutter_output_enable;
                rd_mux[`BIT_FAST_COUNT_LO +: 3] = fast_shutter_count;
            end
            `ADDR_SWEEP_REPEAT: begin
                rd_mux[11:0] = sweep_repeat_region0;
                rd_mux[`BIT_HIGH_FIELD_LO +: 12] = sweep_repeat_region3;
            end
            `ADDR_SHUT_SET1: begin
                rd_mux[8:0] = shutter_set1_fall_pos;
                rd_mux[`BIT_HIGH_FIELD_LO +: 9] = shutter_set1_rise_pos;
            end
            `ADDR_SHUT_SET2: begin
                rd_mux[8:0] = shutter_set2_fall_pos;
                rd_mux[`BIT_HIGH_FIELD_LO +: 9] = shutter_set2_rise_pos;
            end
            `ADDR_SHUT_SELECT: begin
                rd_mux[0] = shutter_toggle_set_select;
            end
            `ADDR_STATUS: begin
                rd_mux[10:0] = shut_left;
                rd_mux[`BIT_STAT_SWEEP] = SWEEP_HOLD;
                rd_mux[`BIT_STAT_SHUT_LINE] = shut_line;
            end
            default: begin
                if (REG_ADDR >= `ADDR_AUX_PHASE1 && REG_ADDR < `ADDR_SHUT_SET1) begin
                    rd_mux[12:0] = aux_vpulse_start_pos[REG_ADDR[1:0] - 2'h1];
                    rd_mux[`BIT_HIGH_FIELD_LO +: 13] = aux_vpulse_end_pos[REG_ADDR[1:0] - 2'h1];
                end
            end
        endcase
    end

    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA <= `REG_RESET;
        end else if (REG_RD) begin
            REG_RDATA <= rd_mux;
        end
    end

    // Line, field and pixel counters
    assign sg_line_now = (line_num == {1'b0, SENSOR_GATE_LINE});

    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            line_pixel_counter <= 13'h0000;
            sensor_gate_pixel_counter <= 13'h0000;
            line_num <= 8'h00;
        end else begin
            if (LINE_SYNC) begin
                line_pixel_counter <= 13'h0000;
            end else if (line_pixel_counter != `PIXEL_COUNT_MAX) begin
                line_pixel_counter <= line_pixel_counter + 13'h0001;
            end
            if (FIELD_SYNC) begin
                line_num <= 8'h00;
            end else if (LINE_SYNC && line_num != `LINE_NUM_MAX) begin
                line_num <= line_num + 8'h01;
            end
            // Restarts at each line so it reads zero at the sensor-gate line start
            if (LINE_SYNC || FIELD_SYNC) begin
                sensor_gate_pixel_counter <= 13'h0000;
            end else if (sensor_gate_pixel_counter != `PIXEL_COUNT_MAX) begin
                sensor_gate_pixel_counter <= sensor_gate_pixel_counter + 13'h0001;
            end
        end
    end

    // Sweep repetition control
    assign sweep_r0 = (REGION == 3'h0) && sweep_region_select[0];
    assign sweep_r3 = (REGION == 3'h3) && sweep_region_select[1];
    assign sweep_on = sweep_r0 || sweep_r3;
    assign sweep_target = sweep_r0 ? sweep_repeat_region0 : sweep_repeat_region3;
    // Hold tells the sequencer to run across line ends until the count is met
    assign SWEEP_HOLD = sweep_on && (sweep_done < sweep_target);

    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            last_region <= 3'h0;
            sweep_done <= 12'h000;
        end else begin
            last_region <= REGION;
            if (REGION != last_region || FIELD_SYNC) begin
                sweep_done <= 12'h000;
            end else if (SWEEP_HOLD && VPULSE_DONE) begin
                sweep_done <= sweep_done + 12'h001;
            end
        end
    end

    // Auxiliary vertical pulse, one slice per phase
    genvar ph;
    generate
        for (ph = 0; ph < 4; ph = ph + 1) begin : g_phase
            reg aux_wave;
            reg vout;
            wire and_mode;
            assign and_mode = aux_vpulse_logic_select[ph];

            always @(posedge CLOCK or negedge RST_B) begin
                if (!RST_B) begin
                    aux_vpulse_start_pos[ph] <= 13'h0000;
                    aux_vpulse_end_pos[ph] <= 13'h0000;
                end else if (REG_WR && REG_ADDR == `ADDR_AUX_PHASE1 + ph) begin
                    aux_vpulse_start_pos[ph] <= REG_WDATA[12:0];
                    aux_vpulse_end_pos[ph] <= REG_WDATA[`BIT_HIGH_FIELD_LO +: 13];
                end
            end

            always @(posedge CLOCK or negedge RST_B) begin
                if (!RST_B) begin
                    aux_wave <= 1'b0;
                    vout <= 1'b0;
                end else begin
                    // Start level: high for AND, low for OR
                    if (LINE_SYNC || !sg_line_now) begin
                        aux_wave <= and_mode;
                    end else if (sensor_gate_pixel_counter == aux_vpulse_start_pos[ph]) begin
                        aux_wave <= ~and_mode;
                    end else if (sensor_gate_pixel_counter == aux_vpulse_end_pos[ph]) begin
                        aux_wave <= and_mode;
                    end
                    if (aux_vpulse_enable && sg_line_now) begin
                        vout <= and_mode ? (VPHASE_IN[ph] & aux_wave) : (VPHASE_IN[ph] | aux_wave);
                    end else begin
                        vout <= VPHASE_IN[ph];
                    end
                end
            end
            assign VPHASE_OUT[ph] = vout;
        end
    endgenerate

    // Substrate-clear line selection
    assign next_armed = shut_armed || sg_line_now;

    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            shut_left <= 11'h000;
            shut_armed <= 1'b0;
            first_pending <= 1'b0;
            shut_line <= 1'b0;
            skip_line <= 1'b0;
        end else if (FIELD_SYNC) begin
            shut_left <= shutter_pulse_count;
            shut_armed <= 1'b0;
            first_pending <= 1'b1;
            shut_line <= 1'b0;
            skip_line <= 1'b0;
        end else if (LINE_SYNC) begin
            // Arming on the sensor-gate line makes the next line the first one
            shut_armed <= next_armed;
            shut_line <= next_armed && (shut_left != 11'h000);
            skip_line <= next_armed && first_pending && shutter_first_pulse_skip;
            if (next_armed) begin
                first_pending <= 1'b0;
            end
            // The skipped pulse still spends one count of the field
            if (next_armed && shut_left != 11'h000) begin
                shut_left <= shut_left - 11'h001;
            end
        end
    end

    // Pulse slots: used even slots low, odd slots high, each one toggle-set width long
    assign fall_pos = shutter_toggle_set_select ? shutter_set2_fall_pos : shutter_set1_fall_pos;
    assign rise_pos = shutter_toggle_set_select ? shutter_set2_rise_pos : shutter_set1_rise_pos;
    assign width = rise_pos - fall_pos;
    assign fall_hit = (line_pixel_counter < `LINE_PIX_SPAN) && (line_pixel_counter[8:0] == fall_pos)
        && (rise_pos > fall_pos);
    assign slot_pair = slot[3:1];
    assign slot_used = (slot_pair == 3'h0) || ((fast_shutter_count != 3'h0)
        && (fast_shutter_mode ? (slot_pair <= fast_shutter_count) : (slot_pair == fast_shutter_count)));
    assign low_now = slot_run && !slot[0] && slot_used;

    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            slot_run <= 1'b0;
            slot <= 4'h0;
            slot_cnt <= 9'h000;
        end else if (LINE_SYNC || FIELD_SYNC) begin
            slot_run <= 1'b0;
            slot <= 4'h0;
            slot_cnt <= 9'h000;
        end else if (!slot_run) begin
            if (shut_line && fall_hit) begin
                slot_run <= 1'b1;
                slot <= 4'h0;
                slot_cnt <= 9'h000;
            end
        end else if (slot_cnt == width - 9'h001) begin
            slot_cnt <= 9'h000;
            if (slot == `SHUT_SLOT_LAST) begin
                slot_run <= 1'b0;
            end else begin
                slot <= slot + 4'h1;
            end
        end else begin
            slot_cnt <= slot_cnt + 9'h001;
        end
    end

    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            SUBSTRATE_CLEAR <= 1'b1;
        end else begin
            SUBSTRATE_CLEAR <= ~(shutter_output_enable && shut_line && !skip_line && low_now);
        end
    end

endmodule // ccd_sweep_shutter_timing

// file: ccd_timing_consts.vh
/*
 Register offsets, field positions and reset values for the sweep,
 auxiliary vertical pulse and substrate-clear timing block.
 Assumes inclusion by its bare name from the design file.
*/
`ifndef CCD_TIMING_CONSTS_VH
`define CCD_TIMING_CONSTS_VH

// Control registers at their printed addresses
`define ADDR_SHUTTER_CTRL 8'h01
`define ADDR_AUX_CTRL 8'h0a
`define ADDR_SHUTTER_NUM 8'h0b

// Further registers
`define ADDR_SWEEP_REPEAT 8'h20
`define ADDR_AUX_PHASE1 8'h21
`define ADDR_SHUT_SET1 8'h25
`define ADDR_SHUT_SET2 8'h26
`define ADDR_SHUT_SELECT 8'h27
`define ADDR_STATUS 8'h28

// Field positions, address 0x01
`define BIT_FIRST_PULSE_SKIP 0
`define BIT_FAST_MODE 1
// Field positions, address 0x0a
`define BIT_SWEEP_SEL_LO 0
`define BIT_AUX_ENABLE 2
`define BIT_AUX_LOGIC_LO 3
// Field positions, address 0x0b
`define BIT_SHUT_COUNT_LO 0
`define BIT_SHUT_ENABLE 11
`define BIT_FAST_COUNT_LO 12
// Upper half-word of the paired-position registers
`define BIT_HIGH_FIELD_LO 16
// Status register
`define BIT_STAT_SWEEP 16
`define BIT_STAT_SHUT_LINE 17

// Limits
`define SWEEP_REPEAT_MAX 12'h800
`define SHUT_SLOT_LAST 4'hf
`define LINE_NUM_MAX 8'hff
`define PIXEL_COUNT_MAX 13'h1fff
`define LINE_PIX_SPAN 13'h0200

// Reset value of every register field
`define REG_RESET 32'h00000000

`endif

// file: ccd_sweep_shutter_timing_asserts.sv
/* Checker of the timing block's ports.
   Assumes a bind to its top module. */
`include "ccd_timing_consts.vh"
`timescale 1ns/100ps
module ccd_sweep_shutter_timing_asserts (
    // Clock and reset
    input wire CLOCK,
    input wire RST_B,
    // Register port
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire [31:0] REG_RDATA,
    // Timing, sequencer and outputs
    input wire LINE_SYNC,
    input wire FIELD_SYNC,
    input wire [6:0] SENSOR_GATE_LINE,
    input wire [2:0] REGION,
    input wire VPULSE_DONE,
    input wire [3:0] VPHASE_IN,
    input wire SWEEP_HOLD,
    input wire [3:0] VPHASE_OUT,
    input wire SUBSTRATE_CLEAR
);
    // Shadows of written fields, updated on the same edge as the registers
    reg [1:0] sel;
    reg aux_en, sh_en, tsel;
    reg [3:0] lsel;
    reg [2:0] fast, fast_line;
    reg [8:0] fall1, rise1, fall2, rise2;
    reg [9:0] lowcnt;
    reg [7:0] nfall;
    wire [8:0] width = tsel ? rise2 - fall2 : rise1 - fall1;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    always @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            {sel, aux_en, lsel, sh_en, fast, fast_line, tsel} <= 15'h0000;
            {fall1, rise1, fall2, rise2} <= 36'h000000000;
            lowcnt <= 10'h000;
            nfall <= 8'h00;
        end else begin
            if (REG_WR && REG_ADDR == `ADDR_AUX_CTRL)
                {lsel, aux_en, sel} <= REG_WDATA[6:0];
            if (REG_WR && REG_ADDR == `ADDR_SHUTTER_NUM)
                {fast, sh_en} <= REG_WDATA[14:11];
            if (REG_WR && REG_ADDR == `ADDR_SHUT_SET1)
                {rise1, fall1} <= {REG_WDATA[24:16], REG_WDATA[8:0]};
            if (REG_WR && REG_ADDR == `ADDR_SHUT_SET2)
                {rise2, fall2} <= {REG_WDATA[24:16], REG_WDATA[8:0]};
            if (REG_WR && REG_ADDR == `ADDR_SHUT_SELECT)
                tsel <= REG_WDATA[0];
            lowcnt <= SUBSTRATE_CLEAR ? 10'h000 : lowcnt + 10'h001;
            nfall <= LINE_SYNC ? 8'h00 : nfall + {7'h00, $fell(SUBSTRATE_CLEAR)};
            // Any fast setting seen during a line excuses extra pulses in it
            fast_line <= LINE_SYNC ? fast : (fast_line | fast);
        end
    end

    property p_hold_region;
        SWEEP_HOLD |-> (REGION == 3'h0 || REGION == 3'h3);
    endproperty
    a_hold_region: assert property (p_hold_region) else $error("hold region");
    property p_hold_sel;
        SWEEP_HOLD |-> ((REGION == 3'h0 && sel[0]) || (REGION == 3'h3 && sel[1]));
    endproperty
    a_hold_sel: assert property (p_hold_sel) else $error("hold select");
    property p_shut_off;
        (!sh_en ##1 !sh_en) |-> SUBSTRATE_CLEAR;
    endproperty
    a_shut_off: assert property (p_shut_off) else $error("clear disabled");
    property p_aux_off;
        (!aux_en ##1 !aux_en) |-> VPHASE_OUT == $past(VPHASE_IN);
    endproperty
    a_aux_off: assert property (p_aux_off) else $error("aux off");
    property p_and_mask;
        (VPHASE_OUT & $past(lsel) & ~$past(VPHASE_IN)) == 4'h0;
    endproperty
    a_and_mask: assert property (p_and_mask) else $error("AND mask");
    property p_or_mask;
        (~VPHASE_OUT & ~$past(lsel) & $past(VPHASE_IN)) == 4'h0;
    endproperty
    a_or_mask: assert property (p_or_mask) else $error("OR mask");
    property p_shut_width;
        $rose(SUBSTRATE_CLEAR) |-> lowcnt == {1'b0, width};
    endproperty
    a_shut_width: assert property (p_shut_width) else $error("clear width");
    property p_one_per_line;
        (LINE_SYNC && fast_line == 3'h0) |-> nfall <= 8'h01;
    endproperty
    a_one_per_line: assert property (p_one_per_line) else $error("one per line");

    c_sweep: cover property (SWEEP_HOLD && VPULSE_DONE);
    c_pulse: cover property ($rose(SUBSTRATE_CLEAR));
    c_aux: cover property (VPHASE_OUT != $past(VPHASE_IN));
endmodule // ccd_sweep_shutter_timing_asserts

// file: ccd_sensor_model.sv
/* Passive model of the sensor's vertical and substrate clock inputs.
   Assumes one-cycle line syncs. */
`timescale 1ns/100ps
module ccd_sensor_model (
    // Clock and framing
    input wire clock,
    input wire line_sync,
    // Sensor inputs and the phase they should follow
    input wire sub_clear,
    input wire vphase,
    input wire vphase_ref,
    // Per-line figures
    output reg [7:0] falls,
    output reg [12:0] first_low,
    output reg [12:0] last_low,
    output reg [12:0] dif_first,
    output reg [12:0] dif_cnt
);
    reg [12:0] pix;
    reg sub_last, ref_d;
    always @(posedge clock) begin
        sub_last <= sub_clear;
        ref_d <= vphase_ref;
        if (line_sync) begin
            pix <= 13'h0000;
            falls <= 8'h00;
            {first_low, last_low, dif_first} <= 39'h7fffffffff;
            dif_cnt <= 13'h0000;
        end else begin
            pix <= pix + 13'h0001;
            // A pulse is taken at its falling edge
            if (sub_last && !sub_clear) begin
                falls <= falls + 8'h01;
                last_low <= pix;
                if (falls == 8'h00)
                    first_low <= pix;
            end
            // An unknown level counts as a difference
            if (vphase !== ref_d) begin
                dif_cnt <= dif_cnt + 13'h0001;
                if (dif_cnt == 13'h0000)
                    dif_first <= pix;
            end
        end
    end
endmodule // ccd_sensor_model

// file: ccd_sweep_aux_vertical_shutter_timing_bench.sv
/* Self-checking bench for the sweep, auxiliary pulse and shutter block.
   Assumes the checker and the sensor model are compiled before it. */
`include "ccd_timing_consts.vh"
`timescale 1ns/100ps
module ccd_sweep_aux_vertical_shutter_timing_bench;
    reg CLOCK = 1'b0, RST_B = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
    reg LINE_SYNC = 1'b0, FIELD_SYNC = 1'b0, VPULSE_DONE = 1'b0;
    reg [7:0] REG_ADDR = 8'h00;
    reg [31:0] REG_WDATA = 32'h00000000;
    reg [6:0] SENSOR_GATE_LINE = 7'h03;
    reg [2:0] REGION = 3'h1;
    reg [3:0] VPHASE_IN = 4'h0;
    wire [31:0] REG_RDATA;
    wire SWEEP_HOLD, SUBSTRATE_CLEAR;
    wire [3:0] VPHASE_OUT;
    wire [7:0] falls;
    wire [12:0] first_low, last_low, dif_first, dif_cnt;
    integer n_fail = 0, cmp_count = 0, i, s;
    logic [31:0] rt [0:4][0:2];
    logic [31:0] ft [0:7][0:10];

    ccd_sweep_shutter_timing u_ccd_sweep_shutter_timing (.*);
    ccd_sensor_model u_ccd_sensor_model (.clock(CLOCK), .line_sync(LINE_SYNC), .sub_clear(SUBSTRATE_CLEAR),
        .vphase(VPHASE_OUT[0]), .vphase_ref(VPHASE_IN[0]), .falls(falls), .first_low(first_low),
        .last_low(last_low), .dif_first(dif_first), .dif_cnt(dif_cnt));

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("ERROR %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        begin
            @(posedge CLOCK);
            REG_ADDR <= a;
            REG_WDATA <= d;
            REG_WR <= 1'b1;
            @(posedge CLOCK);
            REG_WR <= 1'b0;
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        begin
            @(posedge CLOCK);
            REG_ADDR <= a;
            REG_RD <= 1'b1;
            @(posedge CLOCK);
            REG_RD <= 1'b0;
            @(posedge CLOCK);
            #1 chk("read data", e, REG_RDATA);
        end
    endtask
    // A line is long enough for the slowest fast-shutter burst to finish
    task line(input logic f);
        begin
            @(posedge CLOCK);
            LINE_SYNC <= 1'b1;
            FIELD_SYNC <= f;
            @(posedge CLOCK);
            LINE_SYNC <= 1'b0;
            FIELD_SYNC <= 1'b0;
            repeat (180) @(posedge CLOCK);
            #1;
        end
    endtask
    task run_field(input integer r);
        integer k;
        begin
            wr(`ADDR_SHUTTER_CTRL, ft[r][0]);
            wr(`ADDR_AUX_CTRL, ft[r][1]);
            wr(`ADDR_SHUTTER_NUM, ft[r][2]);
            wr(`ADDR_SHUT_SELECT, ft[r][3]);
            @(posedge CLOCK);
            VPHASE_IN <= ft[r][4][3:0];
            for (k = 0; k < 8; k = k + 1) begin
                line(k == 0);
                s = (k >= ft[r][5] && k < ft[r][5] + ft[r][6]);
                chk("pulses in line", s ? ft[r][7] : 0, {24'h0, falls});
                if (s) begin
                    chk("first fall", ft[r][8], {19'h0, first_low});
                    chk("last fall", ft[r][9], {19'h0, last_low});
                end
                chk("aux span", k == 3 ? ft[r][10] : 0, {19'h0, dif_cnt});
                if (k == 3 && ft[r][10] != 0)
                    chk("aux start", 32'h0000000c, {19'h0, dif_first});
            end
        end
    endtask
    task sweep(input logic [2:0] r, input logic on, input integer tgt);
        integer k;
        begin
            @(posedge CLOCK);
            REGION <= r;
            @(posedge CLOCK);
            #1 chk("sweep hold", on, SWEEP_HOLD);
            for (k = 0; k < tgt && on; k = k + 1) begin
                @(posedge CLOCK);
                VPULSE_DONE <= 1'b1;
                @(posedge CLOCK);
                VPULSE_DONE <= 1'b0;
                #1 chk("sweep hold count", k < tgt - 1, SWEEP_HOLD);
            end
        end
    endtask
    task conclude;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
            if (n_fail == 0 && cmp_count > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    initial begin
        forever #5 CLOCK = ~CLOCK;
    end
    initial begin
        #400000;
        n_fail = n_fail + 1;
        conclude;
    end
    initial begin
        // Address, write data, read-back; repeat counts saturate at 2048
        rt = '{'{1, 3, 3}, '{'h0b, 'hffff, 'h7fff}, '{'h20, 'h0fff0fff, 'h08000800},
            '{'h25, 'hffffffff, 'h01ff01ff}, '{'h30, 'hffffffff, 0}};
        // 0x01, 0x0a, 0x0b, 0x27, phase in, first line, lines, pulses, first, last, aux span
        ft = '{'{0, 4, 'h802, 0, 0, 4, 2, 1, 22, 22, 10}, '{1, 0, 'h802, 0, 0, 5, 1, 1, 22, 22, 0},
            '{0, 12, 'h803, 1, 1, 4, 3, 1, 42, 42, 10}, '{0, 4, 'h002, 0, 0, 4, 0, 1, 22, 22, 10},
            '{0, 4, 'h800, 0, 0, 4, 0, 1, 22, 22, 10}, '{0, 4, 'h3802, 0, 0, 4, 2, 2, 22, 70, 10},
            '{2, 4, 'h3802, 0, 0, 4, 2, 4, 22, 70, 10}, '{2, 4, 'h7802, 0, 0, 4, 2, 8, 22, 134, 10}};
        repeat (2) @(posedge CLOCK);
        RST_B <= 1'b1;
        for (i = 0; i < 5; i = i + 1) begin
            rd(rt[i][0][7:0], 32'h00000000);
            wr(rt[i][0][7:0], rt[i][1]);
            rd(rt[i][0][7:0], rt[i][2]);
        end
        wr(`ADDR_SHUT_SET1, 32'h001c0014);
        wr(`ADDR_SHUT_SET2, 32'h002c0028);
        wr(`ADDR_AUX_PHASE1, 32'h0014000a);
        for (i = 0; i < 8; i = i + 1)
            run_field(i);
        wr(`ADDR_SWEEP_REPEAT, 32'h00030002);
        for (i = 0; i < 4; i = i + 1) begin
            wr(`ADDR_AUX_CTRL, i);
            sweep(3'h1, 1'b0, 0);
            sweep(3'h0, i[0], 2);
            sweep(3'h3, i[1], 3);
        end
        conclude;
    end
endmodule // ccd_sweep_aux_vertical_shutter_timing_bench

bind ccd_sweep_shutter_timing ccd_sweep_shutter_timing_asserts u_ccd_sweep_shutter_timing_asserts (.*);
